// file: rtl/astrc_map.svh
`ifndef ASTRC_MAP_SVH
`define ASTRC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets, 8-bit registers on a 3-bit address
`define ASTRC_OFF_BAUD_HI 3'h0
`define ASTRC_OFF_BAUD_LO 3'h1
`define ASTRC_OFF_CONTROL_ONE 3'h2
`define ASTRC_OFF_CONTROL_TWO 3'h3
`define ASTRC_OFF_STATUS_ONE 3'h4
`define ASTRC_OFF_DATA_BUFFER 3'h5
`define ASTRC_OFF_NINTH_BITS 3'h6

////////////////////////////////////////////////////////////////////////////////
// field positions
`define ASTRC_C1_NINE_BIT 4
`define ASTRC_C1_TWO_STOP 3
`define ASTRC_C1_LONG_BREAK 2
`define ASTRC_C1_TX_INVERT 1
`define ASTRC_C1_RX_INVERT 0
`define ASTRC_C2_TX_ENABLE 3
`define ASTRC_C2_RX_ENABLE 2
`define ASTRC_C2_SEND_BREAK 0
`define ASTRC_NB_TX_NINTH 6

////////////////////////////////////////////////////////////////////////////////
// widths, reset values and timing counts
`define ASTRC_MOD_W 13
`define ASTRC_BAUD_RST 13'h0000
`define ASTRC_TX_LINE_RST 1'b1
`define ASTRC_TBE_RST 1'b1
`define ASTRC_FRAME_BASE 4'ha
`define ASTRC_LONG_BREAK_ADD 4'h3
`define ASTRC_DATA_LAST_BASE 4'h8
`define ASTRC_PHASE_LAST 4'hf
`define ASTRC_RT3 4'h2
`define ASTRC_RT5 4'h4
`define ASTRC_RT7 4'h6
`define ASTRC_RT8 4'h7
`define ASTRC_RT9 4'h8
`define ASTRC_RT10 4'h9
`define ASTRC_SAMPLE_SLOT_LAST 4'hf

`endif

// file: rtl/astrc_pkg.sv
`include "astrc_map.svh"

package astrc_pkg;

	typedef enum logic [1:0] {ASTRC_RX_IDLE, ASTRC_RX_START, ASTRC_RX_DATA} astrc_rx_e;

	typedef struct packed {
		logic [`ASTRC_MOD_W-1:0] baud_mod;
		logic [`ASTRC_MOD_W-1:0] baud_cnt;
		logic nine_bit;
		logic two_stop_select;
		logic long_break_select;
		logic tx_invert;
		logic rx_invert;
		logic tx_enable;
		logic rx_enable;
		logic send_break;
		logic [3:0] tx_phase;
		logic [14:0] tx_sh;
		logic [3:0] tx_cnt;
		logic tx_active;
		logic tx_line;
		logic tx_out;
		logic tx_oe;
		logic [8:0] tx_buf;
		logic tx_buffer_empty;
		logic tx_complete;
		logic pre_q;
		logic brk_q;
		astrc_rx_e rx_state;
		logic [3:0] slot;
		logic [3:0] bitn;
		logic [2:0] hist;
		logic [1:0] zeros;
		logic v0;
		logic v1;
		logic [8:0] rx_sh;
		logic nz;
		logic fe_acc;
		logic [8:0] rx_data;
		logic rx_buffer_full;
		logic overrun_flag;
		logic noise_flag;
		logic framing_error_flag;
		logic armed;
		logic [7:0] rdata;
	} astrc_state_s;

endpackage

// file: rtl/astrc_core.sv
// Overview of operation
// - baud timing uses only bus clock
// - output idles high, tx_invert flips it
// - enabling transmitter queues one idle preamble
// - shifter holds 10, 11 or 12 bits
// - free shifter loads buffer, sets buffer empty
// - nothing waiting after stop sets complete
// - pin held until queued work finishes
// - send_break queues break, requeues while set
// - break length ten plus format additions
// - enable off then on queues idle
// - received break gives zeros, framing error
// - rx_invert flips input, rx_enable gates receiver
// - start low, data lsb first, stops high
// - stop moves char, else overrun discards
// - status read then data read clears
// - sixteen sample slots per bit
// - start edge is zero after three ones
// - two of slots 3,5,7 zero validates
// - bits voted on slots 8,9,10
// - disagreeing samples in slots 8,9,10 set noise flag
// - edges inside frame resync slot counter
// - non-break framing error preloads three ones
// - framing error flag blocks buffer transfer
`timescale 1ns/10ps
`include "astrc_map.svh"

module astrc_core
	import astrc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic tx_pin,
	output logic tx_pin_oe,
	input wire logic rx_pin
);

	astrc_state_s st;
	astrc_state_s next_st;
	logic tick;
	logic tx_bit;
	logic tx_load_brk;
	logic tx_load_data;
	logic rx_done;
	logic samp;
	logic edge_seen;
	logic maj;
	logic fe_now;
	logic [1:0] zsum;
	logic [3:0] frame_len;
	logic [3:0] brk_len;
	logic [3:0] data_last;
	logic [14:0] image;
	logic [8:0] rdat;

	function automatic logic vote3(input logic a, input logic b, input logic c);
		vote3 = (a & b) | (a & c) | (b & c);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_st = st;
		next_st.rdata = 8'h00;
		tick = 1'b0;
		tx_bit = 1'b0;
		tx_load_brk = 1'b0;
		tx_load_data = 1'b0;
		rx_done = 1'b0;
		maj = 1'b0;
		fe_now = 1'b0;
		rdat = 9'h000;
		samp = rx_pin ^ st.rx_invert;
		edge_seen = (st.hist == 3'b111) && !samp;
		zsum = st.zeros + {1'b0, ~samp};
		frame_len = `ASTRC_FRAME_BASE + {3'b000, st.nine_bit} + {3'b000, st.two_stop_select};
		brk_len = frame_len + (st.long_break_select ? `ASTRC_LONG_BREAK_ADD : 4'h0);
		data_last = `ASTRC_DATA_LAST_BASE + {3'b000, st.nine_bit};
		// start low, lsb first, stops high
		image = st.nine_bit ? {5'h1f, st.tx_buf, 1'b0} : {6'h3f, st.tx_buf[7:0], 1'b0};

		// bus clock divider, zero modulo stops the tick
		if (st.baud_mod != `ASTRC_BAUD_RST)
		begin
			// a modulo written smaller than the running count must not wait for a wrap
			if (st.baud_cnt >= st.baud_mod - 13'h0001)
			begin
				tick = 1'b1;
				next_st.baud_cnt = 13'h0000;
			end
			else
				next_st.baud_cnt = st.baud_cnt + 13'h0001;
		end
		tx_bit = tick && (st.tx_phase == `ASTRC_PHASE_LAST);
		if (tick)
			next_st.tx_phase = st.tx_phase + 4'h1;

		////////////////////////////////////////////////////////////////////////////////
		// reads first so that hardware sets below win over their clears
		if (rd)
		begin
			case (addr)
				`ASTRC_OFF_BAUD_HI: next_st.rdata = {3'b000, st.baud_mod[12:8]};
				`ASTRC_OFF_BAUD_LO: next_st.rdata = st.baud_mod[7:0];
				`ASTRC_OFF_CONTROL_ONE: next_st.rdata = {3'b000, st.nine_bit, st.two_stop_select,
					st.long_break_select, st.tx_invert, st.rx_invert};
				`ASTRC_OFF_CONTROL_TWO: next_st.rdata = {4'h0, st.tx_enable, st.rx_enable, 1'b0, st.send_break};
				`ASTRC_OFF_STATUS_ONE:
				begin
					next_st.rdata = {st.tx_buffer_empty, st.tx_complete, st.rx_buffer_full, 1'b0,
						st.overrun_flag, st.noise_flag, st.framing_error_flag, 1'b0};
					if (st.rx_buffer_full)
						next_st.armed = 1'b1;
				end
				`ASTRC_OFF_DATA_BUFFER:
				begin
					next_st.rdata = st.rx_data[7:0];
					if (st.armed)
					begin
						next_st.armed = 1'b0;
						next_st.rx_buffer_full = 1'b0;
						next_st.overrun_flag = 1'b0;
						next_st.noise_flag = 1'b0;
						next_st.framing_error_flag = 1'b0;
					end
				end
				`ASTRC_OFF_NINTH_BITS: next_st.rdata = {st.rx_data[8], st.tx_buf[8], 6'h00};
				default: next_st.rdata = 8'h00;
			endcase
		end

		////////////////////////////////////////////////////////////////////////////////
		// loads only on a bit boundary, so every frame starts aligned to the baud clock
		if (tx_bit)
		begin
			if (st.tx_cnt != 4'h0)
			begin
				next_st.tx_line = st.tx_sh[0];
				next_st.tx_sh = {1'b1, st.tx_sh[14:1]};
				next_st.tx_cnt = st.tx_cnt - 4'h1;
			end
			else if (st.pre_q)
			begin
				next_st.pre_q = 1'b0;
				next_st.tx_active = 1'b1;
				next_st.tx_line = 1'b1;
				next_st.tx_sh = 15'h7fff;
				next_st.tx_cnt = frame_len - 4'h1;
			end
			else if (st.brk_q)
			begin
				tx_load_brk = 1'b1;
				next_st.brk_q = st.send_break;
				next_st.tx_active = 1'b1;
				next_st.tx_line = 1'b0;
				next_st.tx_sh = 15'h0000;
				next_st.tx_cnt = brk_len - 4'h1;
			end
			else if (!st.tx_buffer_empty && st.tx_enable)
			begin
				tx_load_data = 1'b1;
				next_st.tx_buffer_empty = 1'b1;
				next_st.tx_active = 1'b1;
				next_st.tx_line = image[0];
				next_st.tx_sh = {1'b1, image[14:1]};
				next_st.tx_cnt = frame_len - 4'h1;
			end
			else
			begin
				next_st.tx_line = 1'b1;
				next_st.tx_active = 1'b0;
				if (st.tx_active)
					next_st.tx_complete = 1'b1;
			end
		end

		////////////////////////////////////////////////////////////////////////////////
		if (wr)
		begin
			case (addr)
				`ASTRC_OFF_BAUD_HI: next_st.baud_mod[12:8] = wdata[4:0];
				`ASTRC_OFF_BAUD_LO: next_st.baud_mod[7:0] = wdata;
				`ASTRC_OFF_CONTROL_ONE:
				begin
					next_st.nine_bit = wdata[`ASTRC_C1_NINE_BIT];
					next_st.two_stop_select = wdata[`ASTRC_C1_TWO_STOP];
					next_st.long_break_select = wdata[`ASTRC_C1_LONG_BREAK];
					next_st.tx_invert = wdata[`ASTRC_C1_TX_INVERT];
					next_st.rx_invert = wdata[`ASTRC_C1_RX_INVERT];
				end
				`ASTRC_OFF_CONTROL_TWO:
				begin
					if (wdata[`ASTRC_C2_TX_ENABLE] && !st.tx_enable)
					begin
						next_st.pre_q = 1'b1;
						next_st.tx_complete = 1'b0;
					end
					// break queued on write of one while send_break is clear
					if (wdata[`ASTRC_C2_SEND_BREAK] && !st.send_break)
					begin
						next_st.brk_q = 1'b1;
						next_st.tx_complete = 1'b0;
					end
					next_st.tx_enable = wdata[`ASTRC_C2_TX_ENABLE];
					next_st.rx_enable = wdata[`ASTRC_C2_RX_ENABLE];
					next_st.send_break = wdata[`ASTRC_C2_SEND_BREAK];
				end
				`ASTRC_OFF_DATA_BUFFER:
				begin
					next_st.tx_buf[7:0] = wdata;
					next_st.tx_buffer_empty = 1'b0;
					next_st.tx_complete = 1'b0;
				end
				`ASTRC_OFF_NINTH_BITS: next_st.tx_buf[8] = wdata[`ASTRC_NB_TX_NINTH];
				default: next_st.tx_buf = next_st.tx_buf;
			endcase
		end

		////////////////////////////////////////////////////////////////////////////////
		// edge history runs on every tick
		if (tick)
			next_st.hist = {st.hist[1:0], samp};
		if (!st.rx_enable)
			next_st.rx_state = ASTRC_RX_IDLE;
		else if (tick)
		begin
			case (st.rx_state)
				ASTRC_RX_IDLE:
				begin
					if (edge_seen)
					begin
						next_st.rx_state = ASTRC_RX_START;
						next_st.slot = 4'h0;
						next_st.zeros = 2'b00;
						next_st.nz = 1'b0;
						next_st.fe_acc = 1'b0;
					end
				end
				ASTRC_RX_START:
				begin
					next_st.slot = st.slot + 4'h1;
					if ((st.slot == `ASTRC_RT3) || (st.slot == `ASTRC_RT5))
						next_st.zeros = zsum;
					// two of three zero, else back to search
					if ((st.slot == `ASTRC_RT7) && (zsum < 2'd2))
						next_st.rx_state = ASTRC_RX_IDLE;
					// start samples in slots 8, 9, 10 that read high are noise
					if ((st.slot >= `ASTRC_RT8) && (st.slot <= `ASTRC_RT10) && samp)
						next_st.nz = 1'b1;
					if (st.slot == `ASTRC_SAMPLE_SLOT_LAST)
					begin
						next_st.rx_state = ASTRC_RX_DATA;
						next_st.bitn = 4'h1;
					end
				end
				ASTRC_RX_DATA:
				begin
					next_st.slot = edge_seen ? 4'h0 : st.slot + 4'h1;
					if (st.slot == `ASTRC_RT8)
						next_st.v0 = samp;
					if (st.slot == `ASTRC_RT9)
						next_st.v1 = samp;
					if (st.slot == `ASTRC_RT10)
					begin
						maj = vote3(st.v0, st.v1, samp);
						if ((st.v0 != st.v1) || (st.v1 != samp))
							next_st.nz = 1'b1;
						if (st.bitn <= data_last)
							next_st.rx_sh = {maj, st.rx_sh[8:1]};
						else if (!maj)
							next_st.fe_acc = 1'b1;
						if (st.bitn == frame_len - 4'h1)
						begin
							rx_done = 1'b1;
							next_st.rx_state = ASTRC_RX_IDLE;
						end
						else
							next_st.bitn = st.bitn + 4'h1;
					end
				end
				default: next_st.rx_state = ASTRC_RX_IDLE;
			endcase
		end

		if (rx_done)
		begin
			fe_now = next_st.fe_acc;
			rdat = st.nine_bit ? next_st.rx_sh : {1'b0, next_st.rx_sh[8:1]};
			if (fe_now && (rdat != 9'h000))
				next_st.hist = 3'b111;
			// no transfer while framing flag stands
			if (!next_st.framing_error_flag)
			begin
				if (next_st.rx_buffer_full)
					next_st.overrun_flag = 1'b1;
				else
				begin
					next_st.rx_data = rdat;
					next_st.rx_buffer_full = 1'b1;
					next_st.noise_flag = next_st.nz;
					// break lands as zeros with framing error
					next_st.framing_error_flag = fe_now;
				end
			end
		end

		// polarity applied at the pin register
		next_st.tx_out = next_st.tx_line ^ next_st.tx_invert;
		// keep driving until queued work is out
		next_st.tx_oe = next_st.tx_enable | next_st.tx_active | next_st.pre_q | next_st.brk_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.tx_line <= `ASTRC_TX_LINE_RST;
			st.tx_out <= `ASTRC_TX_LINE_RST;
			st.tx_buffer_empty <= `ASTRC_TBE_RST;
		end
		else
			st <= next_st;
	end

	assign rdata = st.rdata;
	assign tx_pin = st.tx_out;
	assign tx_pin_oe = st.tx_oe;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence stat_rd_s;
		rd && (addr == `ASTRC_OFF_STATUS_ONE) && st.rx_buffer_full;
	endsequence
	sequence data_rd_s;
		rd && (addr == `ASTRC_OFF_DATA_BUFFER) && !rx_done;
	endsequence

	tick_spacing_a: assert property (tick && (st.baud_mod > 13'h0002) && !wr ##1 !wr |-> !tick ##1 !tick)
		else $error("sample tick came early");
	idle_level_a: assert property (!st.tx_active && (st.tx_cnt == 4'h0) |-> tx_pin == ~st.tx_invert)
		else $error("idle output not at idle level");
	preamble_q_a: assert property (wr && (addr == `ASTRC_OFF_CONTROL_TWO) && wdata[`ASTRC_C2_TX_ENABLE]
		&& !st.tx_enable |=> st.pre_q)
		else $error("enable did not queue preamble");
	load_flag_a: assert property (tx_load_data |=> st.tx_buffer_empty && st.tx_active && !tx_pin_oe == 1'b0)
		else $error("load did not set buffer empty");
	complete_set_a: assert property (tx_bit && st.tx_active && (st.tx_cnt == 4'h0) && !st.pre_q
		&& !st.brk_q && st.tx_buffer_empty && !wr |=> st.tx_complete && st.tx_line ##1 !st.tx_active)
		else $error("complete not set at end");
	pin_held_a: assert property (st.tx_active || st.pre_q || st.brk_q |-> tx_pin_oe)
		else $error("pin released with work pending");
	break_len_a: assert property (tx_load_brk |=> (st.tx_cnt == $past(brk_len) - 4'h1) && !st.tx_line)
		else $error("break length wrong");
	break_again_a: assert property (tx_load_brk && st.send_break |=> st.brk_q)
		else $error("held break not requeued");
	overrun_a: assert property (rx_done && st.rx_buffer_full && !st.framing_error_flag && !rd
		|=> st.overrun_flag && $stable(st.rx_data))
		else $error("overrun not flagged");
	full_clear_a: assert property (stat_rd_s ##[1:2] data_rd_s |=> !st.rx_buffer_full)
		else $error("two step read did not clear");
	start_reject_a: assert property (st.rx_enable && tick && (st.rx_state == ASTRC_RX_START)
		&& (st.slot == `ASTRC_RT7) && (zsum < 2'd2) |=> st.rx_state == ASTRC_RX_IDLE)
		else $error("noise accepted as start");
	fe_block_a: assert property (rx_done && st.framing_error_flag && !rd |=> $stable(st.rx_data)
		&& st.framing_error_flag)
		else $error("transfer despite framing error");

endmodule // astrc_core

// file: sim/astrc_remote.sv
`timescale 1ns/10ps

module astrc_remote
(
	input wire logic clock,
	input wire logic tx_pin,
	output logic rx_pin
);
	int nine = 0;
	int inv = 0;
	int rx_q[$];
	int v;

	initial rx_pin = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// two idle bits lead each frame so a change of inv settles before the start bit
	// frame out lsb first
	task automatic send(input int d, input int stp, input int gl);
		int lv;
		for (int b = -2; b < 12 + nine; b++)
		begin
			lv = (b < 0) ? 1 : (b == 0) ? 0 : (b <= 8 + nine) ? d >> (b - 1) & 1 : (b == 9 + nine) ? stp : 1;
			for (int s = 0; s < 16; s++)
			begin
				@(posedge clock);
				rx_pin <= lv[0] ^ inv[0] ^ (b == gl && s == 8);
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// stop bit is stored inverted, so a clean frame decodes to its data alone
	// decode tx frames
	initial
	begin
		forever
		begin
			@(negedge tx_pin);
			repeat (8) @(posedge clock);
			v = 0;
			for (int b = 0; b <= 8 + nine; b++)
			begin
				repeat (16) @(posedge clock);
				#1 v = v | (tx_pin << b);
			end
			rx_q.push_back(v ^ (1 << (8 + nine)));
		end
	end
endmodule // astrc_remote

// file: sim/tb_async_serial_tx_rx_core.sv
`timescale 1ns/10ps
`include "astrc_map.svh"

module tb_async_serial_tx_rx_core;
	logic clock = 1'b0;
	logic rst_n;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic tx_pin;
	logic tx_pin_oe;
	logic rx_pin;
	logic [7:0] v;
	int n_mismatch = 0;
	int n_tests = 0;
	int seed = 61493;
	int run = 0;
	int cyc = 0;
	int rise = 0;
	int low_q[$];
	int exp_q[$];
	int d;
	int c;

	astrc_core DUT (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .rx_pin(rx_pin));
	astrc_remote remote (.clock(clock), .tx_pin(tx_pin), .rx_pin(rx_pin));

	initial
	begin
		forever #20 clock = ~clock;
	end

	// low runs on the line, in clocks, measure break length
	// rise marks the clock after a bit boundary, so the tx phase is known
	always @(posedge clock)
	begin
		cyc++;
		if (tx_pin === 1'b0)
			run++;
		else if (run > 0)
		begin
			rise = cyc;
			low_q.push_back(run);
			run = 0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wreg(input logic [2:0] a, input logic [7:0] x);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= x;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [2:0] a);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %0t value %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_num(input int g, input int e);
		n_tests++;
		if (g != e)
		begin
			n_mismatch++;
			$display("unexpected %0t count %0d expected %0d", $time, g, e);
		end
	endtask

	// bounded poll; a hang shows up as a flag mismatch
	task automatic wait_tc;
		v = 8'h00;
		for (int i = 0; i < 400 && v[6] !== 1'b1; i++)
			rreg(`ASTRC_OFF_STATUS_ONE);
	endtask

	// status then data read: the full clearing sequence
	task automatic rx_check(input int x, input logic [7:0] st);
		rreg(`ASTRC_OFF_STATUS_ONE);
		chk_reg(v & 8'h2e, st);
		rreg(`ASTRC_OFF_DATA_BUFFER);
		chk_reg(v, x[7:0]);
	endtask

	task automatic end_of_test;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		end_of_test;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_n <= 1'b0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		rreg(`ASTRC_OFF_STATUS_ONE);
		chk_reg(v, 8'h80);
		chk_reg({6'h00, tx_pin_oe, tx_pin}, 8'h01);
		wreg(3'h7, 8'hff);
		rreg(3'h7);
		chk_reg(v, 8'h00);
		wreg(`ASTRC_OFF_BAUD_LO, 8'h03);
		repeat (12) @(posedge clock);
		wreg(`ASTRC_OFF_BAUD_LO, 8'h01);
		rreg(`ASTRC_OFF_BAUD_LO);
		chk_reg(v, 8'h01);
		wreg(`ASTRC_OFF_CONTROL_TWO, 8'h0c);
		d = $random(seed) & 255;
		wreg(`ASTRC_OFF_DATA_BUFFER, d[7:0]);
		exp_q.push_back(d);
		for (c = 0; c < 300 && tx_pin !== 1'b0; c++)
			@(posedge clock);
		chk_num(c >= 155 && c <= 180, 1);
		wreg(`ASTRC_OFF_CONTROL_TWO, 8'h04);
		chk_reg({7'h00, tx_pin_oe}, 8'h01);
		wait_tc;
		chk_reg(v & 8'hc0, 8'hc0);
		chk_reg({6'h00, tx_pin_oe, tx_pin}, 8'h01);
		wreg(`ASTRC_OFF_CONTROL_TWO, 8'h0c);
		for (int f = 0; f < 4; f++)
		begin
			remote.nine = f & 1;
			wreg(`ASTRC_OFF_CONTROL_ONE, {3'h0, f[0], f[1], 3'h0});
			d = $random(seed) & (f[0] ? 511 : 255);
			wreg(`ASTRC_OFF_NINTH_BITS, {1'b0, d[8], 6'h00});
			wreg(`ASTRC_OFF_DATA_BUFFER, d[7:0]);
			exp_q.push_back(d);
			wait_tc;
			chk_reg(v & 8'hc0, 8'hc0);
		end
		chk_num(remote.rx_q.size(), 5);
		while (exp_q.size() > 0 && remote.rx_q.size() > 0)
			chk_num(remote.rx_q.pop_front(), exp_q.pop_front());
		for (int f = 0; f < 8; f++)
		begin
			wreg(`ASTRC_OFF_CONTROL_ONE, {3'h0, f[1], f[0], f[2], 2'h0});
			low_q.delete();
			// pulse send_break mid-bit so one break is queued
			while ((cyc - rise) % 16 != 8)
				@(posedge clock);
			wreg(`ASTRC_OFF_CONTROL_TWO, 8'h0d);
			wreg(`ASTRC_OFF_CONTROL_TWO, 8'h0c);
			wait_tc;
			chk_num(low_q.size() ? low_q[0] : 0, (10 + f[0] + f[1] + 3 * f[2]) * 16);
		end
		remote.nine = 0;
		wreg(`ASTRC_OFF_CONTROL_ONE, 8'h00);
		d = $random(seed) & 255;
		remote.send(d, 1, -1);
		rx_check(d, 8'h20);
		rreg(`ASTRC_OFF_STATUS_ONE);
		chk_reg(v & 8'h2e, 8'h00);
		d = $random(seed) & 255;
		remote.send(d, 1, -1);
		rreg(`ASTRC_OFF_DATA_BUFFER);
		chk_reg(v, d[7:0]);
		rx_check(d, 8'h20);
		c = $random(seed) & 255;
		d = $random(seed) & 255;
		remote.send(c, 1, -1);
		remote.send(d, 1, -1);
		rx_check(c, 8'h28);
		remote.send(d, 1, 3);
		rx_check(d, 8'h24);
		remote.send(d, 0, -1);
		remote.send(c, 1, -1);
		rx_check(d, 8'h22);
		remote.send(0, 0, -1);
		rx_check(0, 8'h22);
		wreg(`ASTRC_OFF_CONTROL_TWO, 8'h08);
		remote.send(d, 1, -1);
		rreg(`ASTRC_OFF_STATUS_ONE);
		chk_reg(v & 8'h2e, 8'h00);
		wreg(`ASTRC_OFF_CONTROL_ONE, 8'h01);
		remote.inv = 1;
		wreg(`ASTRC_OFF_CONTROL_TWO, 8'h0c);
		remote.send(c, 1, -1);
		rx_check(c, 8'h20);
		wreg(`ASTRC_OFF_CONTROL_ONE, 8'h02);
		repeat (2) @(posedge clock);
		#1 chk_reg({7'h00, tx_pin}, 8'h00);
		end_of_test;
	end
endmodule // tb_async_serial_tx_rx_core
